//--- shared/ctw_pkg.sv
// Package for the test, transfer and wait instruction group.
// Assumes a single bus clock and an 8-bit memory port with one-cycle reads.
`default_nettype none
package ctw_pkg;
    localparam logic [7:0] OPC_TEST_DIR    = 8'h3D;
    localparam logic [7:0] OPC_TEST_ACC    = 8'h4D;
    localparam logic [7:0] OPC_TEST_XLO    = 8'h5D;
    localparam logic [7:0] OPC_TEST_IDXO   = 8'h6D;
    localparam logic [7:0] OPC_TEST_IDX    = 8'h7D;
    localparam logic [7:0] OPC_PREFIX      = 8'h9E;
    localparam logic [7:0] OPC_TEST_STKO   = 8'h6D;
    localparam logic [7:0] OPC_SP_TO_X     = 8'h95;
    localparam logic [7:0] OPC_X_TO_SP     = 8'h94;
    localparam logic [7:0] OPC_X_TO_ACC    = 8'h9F;
    localparam logic [7:0] OPC_WAIT        = 8'h8F;
    localparam int         CYC_TEST_REG    = 1;
    localparam int         CYC_TEST_DIR    = 3;
    localparam int         CYC_TEST_IDXO   = 3;
    localparam int         CYC_TEST_IDX    = 2;
    localparam int         CYC_TEST_STKO   = 4;
    localparam int         CYC_XFER        = 2;
    localparam int         CYC_COPY        = 1;
    localparam int         CYC_WAIT        = 1;
    // Flag bit positions: V, H, I, N, Z, C
    localparam int         FLG_V           = 5;
    localparam int         FLG_H           = 4;
    localparam int         FLG_I           = 3;
    localparam int         FLG_N           = 2;
    localparam int         FLG_Z           = 1;
    localparam int         FLG_C           = 0;
    localparam logic [5:0] FLAGS_RST       = 6'h08;
    localparam logic [15:0] SP_RST         = 16'h00_FF;

    typedef struct packed {
        logic [7:0]  acc;
        logic [15:0] hx;
        logic [15:0] sp;
        logic [5:0]  flags;
    } ctw_regs_s;

    typedef struct packed {
        logic        rd;
        logic [15:0] addr;
    } ctw_mem_req_s;
endpackage
`default_nettype wire

//--- rtl/ctw_flag_calc.sv
// Flag update for the test operation: zero is subtracted from an operand.
// Purely combinational; the caller decides when to apply the result.
`timescale 1ns/100ps
`default_nettype none
module ctw_flag_calc (
    input  wire logic [7:0] operand,
    input  wire logic [5:0] flags_in,
    output logic      [5:0] flags_out
);
    import ctw_pkg::*;
    always_comb begin
        flags_out        = flags_in;
        flags_out[FLG_N] = operand[7];
        flags_out[FLG_Z] = (operand == 8'h00);
        flags_out[FLG_V] = 1'b0;
    end
endmodule
`default_nettype wire

//--- rtl/ctw_core.sv
// Execution core for the test, register transfer and wait instructions.
// Assumes memory returns read data in the same cycle the address is issued
// and that an opcode is offered only while ready is high.
// Overview of operation
// - Test sets N,Z, clears V; inherent one cycle
// - Direct test: low-page address, three cycles
// - Indexed offset test adds byte, three cycles
// - Plain indexed test uses index, two cycles
// - Stack offset test: prefixed, four cycles
// - Wait holds core in halt state until interrupt
// - Wait clears mask, one cycle, others kept
`timescale 1ns/100ps
`default_nettype none
module ctw_core (
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    input  wire logic                  op_valid,
    input  wire logic [7:0]            op_code,
    input  wire logic                  op_prefixed,
    input  wire logic [7:0]            op_arg,
    input  wire logic [7:0]            mem_rdata,
    input  wire logic                  irq_pending,
    output logic                       op_ready,
    output ctw_pkg::ctw_mem_req_s      mem_req,
    output ctw_pkg::ctw_regs_s         regs,
    output logic                       core_halted,
    output logic                       irq_take
);
    import ctw_pkg::*;

    typedef enum {ST_IDLE, ST_BUSY, ST_READ, ST_WAIT} ctw_state_e;

    ctw_state_e  state_q;
    logic [2:0]  cnt_q;
    logic [7:0]  op_q;
    logic        pre_q;
    logic        rd_q;
    logic [15:0] addr_q;
    ctw_regs_s   regs_q;
    logic [5:0]  test_flags;
    logic [7:0]  test_src;
    logic        start;

    function automatic logic [2:0] cycles_of(input logic [7:0] op, input logic pre);
        logic [2:0] c;
        c = 3'(CYC_COPY);
        if (pre) begin
            // Other prefixed codes fall through as one-cycle no-ops
            if (op == OPC_TEST_STKO) begin
                c = 3'(CYC_TEST_STKO);
            end
        end else begin
            case (op)
                OPC_TEST_DIR:  c = 3'(CYC_TEST_DIR);
                OPC_TEST_IDXO: c = 3'(CYC_TEST_IDXO);
                OPC_TEST_IDX:  c = 3'(CYC_TEST_IDX);
                OPC_SP_TO_X,
                OPC_X_TO_SP:   c = 3'(CYC_XFER);
                OPC_WAIT:      c = 3'(CYC_WAIT);
                default:       c = 3'(CYC_TEST_REG);
            endcase
        end
        return c;
    endfunction

    assign start       = op_valid && op_ready;
    assign op_ready    = (state_q == ST_IDLE);
    assign core_halted = (state_q == ST_WAIT);
    assign regs        = regs_q;
    assign mem_req     = '{rd: rd_q, addr: addr_q};
    assign irq_take    = core_halted && irq_pending;

    always_comb begin
        test_src = mem_rdata;
        if (start && op_code == OPC_TEST_ACC && !op_prefixed) begin
            test_src = regs_q.acc;
        end else if (start && op_code == OPC_TEST_XLO && !op_prefixed) begin
            test_src = regs_q.hx[7:0];
        end
    end

    ctw_flag_calc ctw_flag_calc_i (
        .operand   (test_src),
        .flags_in  (regs_q.flags),
        .flags_out (test_flags)
    );

    // Sequencer; a memory operand is consumed on the final cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            cnt_q   <= 3'd0;
            op_q    <= 8'h00;
            pre_q   <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        op_q  <= op_code;
                        pre_q <= op_prefixed;
                        cnt_q <= cycles_of(op_code, op_prefixed) - 3'd1;
                        if (op_code == OPC_WAIT && !op_prefixed) begin
                            state_q <= ST_WAIT;
                        end else if (cycles_of(op_code, op_prefixed) > 3'd1) begin
                            state_q <= ST_BUSY;
                        end
                    end
                end
                ST_BUSY: begin
                    cnt_q <= cnt_q - 3'd1;
                    if (cnt_q == 3'd1) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_WAIT: begin
                    if (irq_pending) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Operand address issued on the last cycle, the one in which the operand is consumed
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_q   <= 1'b0;
            addr_q <= 16'h0000;
        end else begin
            rd_q <= 1'b0;
            if (state_q == ST_BUSY && cnt_q == 3'd2 && !(op_q == OPC_TEST_IDX && !pre_q)) begin
                rd_q <= (op_q == OPC_TEST_DIR || op_q == OPC_TEST_IDXO) && !pre_q
                        || (pre_q && op_q == OPC_TEST_STKO);
            end
            if (start && !op_prefixed) begin
                case (op_code)
                    OPC_TEST_DIR: addr_q <= {8'h00, op_arg};
                    OPC_TEST_IDXO: addr_q <= regs_q.hx + {8'h00, op_arg};
                    OPC_TEST_IDX: begin
                        addr_q <= regs_q.hx;
                        rd_q   <= 1'b1;
                    end
                    default: addr_q <= addr_q;
                endcase
            end else if (start && op_code == OPC_TEST_STKO) begin
                addr_q <= regs_q.sp + {8'h00, op_arg};
            end
        end
    end

    // Architectural registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            regs_q <= '{acc: 8'h00, hx: 16'h0000, sp: SP_RST, flags: FLAGS_RST};
        end else if (start && !op_prefixed) begin
            case (op_code)
                OPC_TEST_ACC,
                OPC_TEST_XLO: regs_q.flags <= test_flags;
                OPC_WAIT:     regs_q.flags[FLG_I] <= 1'b0;
                OPC_SP_TO_X:  regs_q.hx <= regs_q.sp + 16'h0001;
                OPC_X_TO_SP:  regs_q.sp <= regs_q.hx - 16'h0001;
                OPC_X_TO_ACC: regs_q.acc <= regs_q.hx[7:0];
                default:      regs_q <= regs_q;
            endcase
        end else if (state_q == ST_BUSY && cnt_q == 3'd1 && (pre_q ? op_q == OPC_TEST_STKO
                     : (op_q == OPC_TEST_DIR || op_q == OPC_TEST_IDXO
                        || op_q == OPC_TEST_IDX))) begin
            regs_q.flags <= test_flags;
        end
    end

    property p_wait_flags;
        @(posedge ref_clk) disable iff (!rstn)
        start && op_code == OPC_WAIT && !op_prefixed |=> !regs_q.flags[FLG_I] && core_halted
            && regs_q.flags[5:4] == $past(regs_q.flags[5:4])
            && regs_q.flags[2:0] == $past(regs_q.flags[2:0]);
    endproperty
    a_wait_flags: assert property (p_wait_flags) else $error("wait flag effect wrong");

    property p_wait_hold;
        @(posedge ref_clk) disable iff (!rstn)
        core_halted && !irq_pending |=> core_halted && !op_ready;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait left early");

    property p_test_reg;
        @(posedge ref_clk) disable iff (!rstn)
        start && op_code == OPC_TEST_ACC && !op_prefixed |=> op_ready
            && regs_q.flags[FLG_Z] == ($past(regs_q.acc) == 8'h00) && !regs_q.flags[FLG_V]
            && regs_q.flags[FLG_C] == $past(regs_q.flags[FLG_C]);
    endproperty
    a_test_reg: assert property (p_test_reg) else $error("accumulator test wrong");

    property p_test_dir;
        @(posedge ref_clk) disable iff (!rstn)
        start && op_code == OPC_TEST_DIR && !op_prefixed |=> !op_ready [*2] ##1 op_ready;
    endproperty
    a_test_dir: assert property (p_test_dir) else $error("direct test length wrong");

    property p_test_idxo;
        @(posedge ref_clk) disable iff (!rstn)
        start && op_code == OPC_TEST_IDXO && !op_prefixed |=> !op_ready ##1 mem_req.rd
            && mem_req.addr == $past(regs_q.hx, 2) + {8'h00, $past(op_arg, 2)} ##1 op_ready;
    endproperty
    a_test_idxo: assert property (p_test_idxo) else $error("indexed offset test wrong");

    property p_test_idx;
        @(posedge ref_clk) disable iff (!rstn)
        start && op_code == OPC_TEST_IDX && !op_prefixed |=> mem_req.rd
            && mem_req.addr == $past(regs_q.hx) ##1 op_ready;
    endproperty
    a_test_idx: assert property (p_test_idx) else $error("plain indexed test wrong");

    property p_test_stko;
        @(posedge ref_clk) disable iff (!rstn)
        start && op_code == OPC_TEST_STKO && op_prefixed |=> !op_ready [*3] ##1 op_ready;
    endproperty
    a_test_stko: assert property (p_test_stko) else $error("stack test length wrong");

    property p_stk_to_idx;
        @(posedge ref_clk) disable iff (!rstn)
        start && op_code == OPC_SP_TO_X && !op_prefixed |=> regs_q.hx == $past(regs_q.sp) + 16'h0001
            && regs_q.flags == $past(regs_q.flags) ##1 op_ready;
    endproperty
    a_stk_to_idx: assert property (p_stk_to_idx) else $error("stack to index wrong");
endmodule
`default_nettype wire

//--- testbench/ctw_core_tb.sv
// Self-checking bench for the test, transfer and wait instruction core.
// Drives opcodes directly and plays a memory that returns read data in the same cycle as the address.
`timescale 1ns/100ps
`default_nettype none
module ctw_core_tb;
    import ctw_pkg::*;
    typedef struct packed {
        ctw_regs_s   regs;
        logic [15:0] addr;
        logic [7:0]  mv;
        logic        mem;
        logic [2:0]  cyc;
    } ctw_note_s;
    logic         ref_clk = 1'b0;
    logic         rstn = 1'b0;
    logic         op_valid = 1'b0;
    logic         op_prefixed = 1'b0;
    logic         irq_pending = 1'b0;
    logic [7:0]   op_code = 8'h00;
    logic [7:0]   op_arg = 8'h00;
    logic [7:0]   mem_rdata = 8'h00;
    logic [7:0]   mv;
    logic         op_ready, core_halted, irq_take;
    logic         act = 1'b0, late = 1'b0, hold = 1'b0;
    ctw_mem_req_s mem_req;
    ctw_regs_s    regs, exp;
    ctw_note_s    q[$];
    int           fails = 0, checked = 0, cnt = 0, k, i;
    integer       seed = 32'h6770;
    logic [7:0]   mcode [4] = '{OPC_TEST_DIR, OPC_TEST_IDXO, OPC_TEST_IDX, OPC_TEST_STKO};

    ctw_core ctw_core_i (.ref_clk(ref_clk), .rstn(rstn), .op_valid(op_valid),
        .op_code(op_code), .op_prefixed(op_prefixed), .op_arg(op_arg),
        .mem_rdata(mem_rdata), .irq_pending(irq_pending), .op_ready(op_ready),
        .mem_req(mem_req), .regs(regs), .core_halted(core_halted), .irq_take(irq_take));

    always #25 ref_clk = ~ref_clk;

    task check(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask

    task final_report;
        $display("Counts: %0d checks, %0d mismatches", checked, fails);
        if (fails == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task wait_ready;
        for (k = 0; k < 20 && op_ready !== 1'b1; k++) @(negedge ref_clk);
        if (k == 20) begin
            check(1'b0, "timeout waiting for ready");
            final_report;
        end
    endtask

    task idle(input int n);
        op_valid <= 1'b0;
        repeat (n) @(negedge ref_clk);
    endtask

    // Builds the expected state, offers the opcode and returns after it is taken
    task automatic issue(input logic [7:0] code, input logic pre, input logic [7:0] arg,
                         input logic [7:0] m);
        ctw_note_s  n;
        logic [7:0] v;
        logic       is_test;
        n = '0;
        v = 8'h00;
        is_test = 1'b1;
        n.cyc = 3'(CYC_TEST_REG);
        n.mv = m;
        if (pre) begin
            n.addr = exp.sp + {8'h00, arg};
            n.cyc = 3'(CYC_TEST_STKO);
        end else case (code)
            OPC_TEST_DIR: begin
                n.addr = {8'h00, arg};
                n.cyc = 3'(CYC_TEST_DIR);
            end
            OPC_TEST_IDXO: begin
                n.addr = exp.hx + {8'h00, arg};
                n.cyc = 3'(CYC_TEST_IDXO);
            end
            OPC_TEST_IDX: begin
                n.addr = exp.hx;
                n.cyc = 3'(CYC_TEST_IDX);
            end
            OPC_TEST_ACC: v = exp.acc;
            OPC_TEST_XLO: v = exp.hx[7:0];
            default: is_test = 1'b0;
        endcase
        n.mem = pre || code inside {OPC_TEST_DIR, OPC_TEST_IDXO, OPC_TEST_IDX};
        if (n.mem) v = m;
        if (is_test) begin
            exp.flags[FLG_N] = v[7];
            exp.flags[FLG_Z] = (v == 8'h00);
            exp.flags[FLG_V] = 1'b0;
        end else begin
            n.cyc = 3'((code == OPC_X_TO_ACC) ? CYC_COPY : CYC_XFER);
            if (code == OPC_SP_TO_X) exp.hx = exp.sp + 16'h0001;
            if (code == OPC_X_TO_SP) exp.sp = exp.hx - 16'h0001;
            if (code == OPC_X_TO_ACC) exp.acc = exp.hx[7:0];
        end
        n.regs = exp;
        op_code <= code;
        op_prefixed <= pre;
        op_arg <= arg;
        op_valid <= 1'b1;
        wait_ready;
        q.push_back(n);
        @(negedge ref_clk);
    endtask

    // Wait is checked directly by the main sequence, so it opens no note
    always @(posedge ref_clk) begin
        if (act) cnt = cnt + 1;
        if (rstn && op_valid && op_ready && !(op_code == OPC_WAIT && !op_prefixed)) begin
            act = 1'b1;
            cnt = 1;
        end
    end

    // Memory-test notes are compared on the second falling edge after ready returns
    always @(negedge ref_clk) begin
        if (late) begin
            late = 1'b0;
            check(regs === q[0].regs, "memory test flags");
            void'(q.pop_front());
        end else if (act && op_ready === 1'b1) begin
            act = 1'b0;
            check(q.size() > 0 && cnt == int'(q[0].cyc), "cycle count");
            if (q[0].mem) late = 1'b1;
            else begin
                check(regs === q[0].regs, "register state");
                void'(q.pop_front());
            end
        end
    end

    // Read data held for two clock cycles, garbage otherwise
    always @(negedge ref_clk) begin
        if (mem_req.rd === 1'b1) begin
            check(q.size() > 0 && q[0].mem && mem_req.addr === q[0].addr, "read address");
            mem_rdata <= q[0].mv;
            hold = 1'b1;
        end else if (hold) hold = 1'b0;
        else mem_rdata <= 8'($random(seed));
    end

    initial begin
        exp = '{8'h00, 16'h0000, SP_RST, FLAGS_RST};
        repeat (3) @(negedge ref_clk);
        check(regs === exp && op_ready === 1'b1 && mem_req.rd === 1'b0, "reset state");
        repeat (2) @(negedge ref_clk);
        rstn <= 1'b1;
        @(negedge ref_clk);
        issue(OPC_TEST_ACC, 1'b0, 8'h00, 8'h00);
        issue(OPC_SP_TO_X, 1'b0, 8'h00, 8'h00);
        issue(OPC_X_TO_ACC, 1'b0, 8'h00, 8'h00);
        issue(OPC_X_TO_SP, 1'b0, 8'h00, 8'h00);
        issue(OPC_TEST_XLO, 1'b0, 8'h00, 8'h00);
        idle(6);
        $display("Test inherent and transfer done");
        for (i = 0; i < 12; i++) begin
            mv = (i < 4) ? 8'h80 : (i < 8) ? 8'h00 : 8'($random(seed));
            issue(mcode[i % 4], i % 4 == 3, 8'($random(seed)), mv);
            idle(6);
        end
        $display("Test memory modes done");
        op_code <= OPC_WAIT;
        op_prefixed <= 1'b0;
        op_valid <= 1'b1;
        @(negedge ref_clk);
        op_valid <= 1'b0;
        exp.flags[FLG_I] = 1'b0;
        check(core_halted === 1'b1 && op_ready === 1'b0, "wait did not halt");
        check(regs === exp, "flags after wait");
        repeat (4) @(negedge ref_clk);
        check(core_halted === 1'b1 && irq_take === 1'b0, "halt not held");
        irq_pending <= 1'b1;
        #1 check(irq_take === 1'b1, "interrupt not taken");
        @(negedge ref_clk);
        irq_pending <= 1'b0;
        wait_ready;
        check(core_halted === 1'b0, "halt not left");
        issue(OPC_TEST_ACC, 1'b0, 8'h00, 8'h00);
        idle(4);
        $display("Test wait done");
        check(q.size() == 0, "results missing");
        final_report;
    end
endmodule
`default_nettype wire
